/* include/sdwb_pkg.sv */
// Purpose: Shared constants and types for the write-burst capture block
// Assumes: Core clock 25 MHz; commands arrive already decoded on the core clock
// Notes: Register map is reached over AHB-Lite, one aligned word per register
package sdwb_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;     // Latency and burst setup
   localparam logic [7:0] STAT_OFS = 8'h04;     // Engine state and counters
   localparam logic [7:0] DATA_OFS = 8'h08;     // Last element accepted into a burst
   localparam logic [7:0] PRE_OFS = 8'h0C;      // Auto-precharge count and last bank
   // Control fields
   localparam int CTRL_CL_LSB = 0;              // cas_latency, 3 bits
   localparam int CTRL_AL_LSB = 4;              // additive_latency, 3 bits
   localparam int CTRL_BL8_BIT = 8;             // burst_length eight when set
   localparam int CTRL_WR_LSB = 9;              // mode_reg_bits_9_to_11 copy
   localparam logic [31:0] CTRL_RST = 32'h0000_0003; // cas_latency 3, BL4
   // Address bit that requests auto precharge
   localparam int AP_BIT = 10;
   // Burst sizes in data elements
   localparam logic [3:0] BURST4 = 4'h4;
   localparam logic [3:0] BURST8 = 4'h8;
   // Spacing of a truncating write, in link clocks
   localparam logic [3:0] TRUNC_GAP = 4'h2;
   // Engine states
   typedef enum logic [1:0] {SDWB_IDLE, SDWB_WAIT, SDWB_DATA} sdwb_state_t;
endpackage : sdwb_pkg

/* include/sdwb_cap_if.sv */
// Purpose: Carrier between the strobe capture leaf and the burst engine
// Assumes: All signals on core_clk
// Notes: One pulse per captured element
`timescale 1ns/1ps
interface sdwb_cap_if #(parameter int DW = 16);
   logic [DW-1:0] capData;   // Element captured at a strobe edge
   logic [1:0] capMask;      // Per-byte mask sampled with it
   logic [1:0] capValid;     // Per-lane edge seen this cycle
   modport leaf (output capData, output capMask, output capValid);
   modport core (input capData, input capMask, input capValid);
endinterface : sdwb_cap_if

/* rtl/sdwb_strobe_cap.sv */
// Purpose: Synchronise the lane strobes and capture data on their edges
// Assumes: Strobe toggles slowly relative to core_clk (oversampled)
// Notes: Each element is taken at a strobe edge after two-flop sync
`timescale 1ns/1ps
module sdwb_strobe_cap #(
   parameter int DW = 16
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [1:0] dqsIn,
   input wire logic [DW-1:0] dqIn,
   input wire logic [1:0] dmIn,
   sdwb_cap_if.leaf cap
);
   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   logic [1:0] dqsMeta_q, dqsSync_q, dqsOld_q; // Strobe chain, meta read only by sync
   logic [DW-1:0] dqMeta_q, dqSync_q;          // Data chain
   logic [1:0] dmMeta_q, dmSync_q;             // Mask chain
   wire [1:0] edgeSeen = dqsSync_q ^ dqsOld_q; // Both edges carry data
   // Two flops before anything looks at pins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         dqsMeta_q <= 2'h0;
         dqsSync_q <= 2'h0;
         dqsOld_q <= 2'h0;
         dqMeta_q <= '0;
         dqSync_q <= '0;
         dmMeta_q <= 2'h0;
         dmSync_q <= 2'h0;
      end else begin
         dqsMeta_q <= dqsIn;
         dqsSync_q <= dqsMeta_q;
         dqsOld_q <= dqsSync_q;
         dqMeta_q <= dqIn;
         dqSync_q <= dqMeta_q;
         dmMeta_q <= dmIn;
         dmSync_q <= dmMeta_q;
      end
   end
   // Lower byte follows lower strobe, upper byte the upper one
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cap.capData <= '0;
         cap.capMask <= 2'h0;
         cap.capValid <= 2'h0;
      end else begin
         cap.capValid <= edgeSeen;
         cap.capMask <= dmSync_q;
         if (edgeSeen[0]) begin
            cap.capData[DW/2-1:0] <= dqSync_q[DW/2-1:0];
         end
         if (edgeSeen[1]) begin
            cap.capData[DW-1:DW/2] <= dqSync_q[DW-1:DW/2];
         end
      end
   end
endmodule : sdwb_strobe_cap

/* rtl/sdwb_write_burst.sv */
// Purpose: Write-burst engine of a synchronous DRAM: latency, capture, auto precharge
// Assumes: Link clock 320 ns sampled by core_clk; commands sampled on link rising edge
// Notes: AHB-Lite slave answers with zero wait states
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module sdwb_write_burst #(
   parameter int DW = 16,
   parameter int AW = 10
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic linkClk,
   input wire logic cmdWrite,
   input wire logic [2:0] cmdBank,
   input wire logic [AW-1:0] cmdCol,
   input wire logic cmdA10,
   input wire logic [1:0] dqsIn,
   input wire logic [DW-1:0] dqIn,
   input wire logic [1:0] dmIn,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic memWe,
   output logic [AW-1:0] memAddr,
   output logic [DW-1:0] memData,
   output logic [1:0] memByteEn,
   output logic apStart,
   output logic [2:0] apBank,
   output logic dqOe
);
   // ----------------------------------------------------------------
   // Link clock and command sampling
   // ----------------------------------------------------------------
   logic lkMeta_q, lkSync_q, lkOld_q;           // Link clock synchroniser
   logic cwMeta_q, cwSync_q, a10Meta_q, a10Sync_q; // Command strobes
   logic [2:0] bkMeta_q, bkSync_q;              // Bank
   logic [AW-1:0] colMeta_q, colSync_q;         // Column
   wire linkRise = lkSync_q & ~lkOld_q;         // One core cycle per link clock
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lkMeta_q <= 1'b0;
         lkSync_q <= 1'b0;
         lkOld_q <= 1'b0;
         cwMeta_q <= 1'b0;
         cwSync_q <= 1'b0;
         a10Meta_q <= 1'b0;
         a10Sync_q <= 1'b0;
         bkMeta_q <= 3'h0;
         bkSync_q <= 3'h0;
         colMeta_q <= '0;
         colSync_q <= '0;
      end else begin
         lkMeta_q <= linkClk;
         lkSync_q <= lkMeta_q;
         lkOld_q <= lkSync_q;
         cwMeta_q <= cmdWrite;
         cwSync_q <= cwMeta_q;
         a10Meta_q <= cmdA10;
         a10Sync_q <= a10Meta_q;
         bkMeta_q <= cmdBank;
         bkSync_q <= bkMeta_q;
         colMeta_q <= cmdCol;
         colSync_q <= colMeta_q;
      end
   end
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;                         // Software setup
   logic [DW-1:0] lastData_q;                   // Last element accepted
   logic [15:0] apCount_q;                      // Auto precharges issued
   wire [2:0] casLat = ctrl_q[sdwb_pkg::CTRL_CL_LSB +: 3];
   wire [2:0] addLat = ctrl_q[sdwb_pkg::CTRL_AL_LSB +: 3];
   wire bl8 = ctrl_q[sdwb_pkg::CTRL_BL8_BIT];
   wire [3:0] burstLen = bl8 ? sdwb_pkg::BURST8 : sdwb_pkg::BURST4;
   // Write latency is read latency (AL+CL) less one clock
   wire [3:0] writeLat = 4'({1'b0, addLat} + {1'b0, casLat} - 4'h1);
   // ----------------------------------------------------------------
   // Burst engine
   // ----------------------------------------------------------------
   sdwb_pkg::sdwb_state_t state_q;
   logic [3:0] latCnt_q;                        // Clocks left to first strobe
   logic [3:0] elemCnt_q;                       // Elements left in burst
   logic [3:0] sinceCmd_q;                      // Clocks since last WRITE
   logic [AW-1:0] col_q;                        // Next column to store
   logic apPend_q;                              // Auto precharge wanted
   logic [2:0] bank_q;                          // Bank of current burst
   logic pendValid_q, pendAp_q;                 // Queued WRITE during a burst
   logic [2:0] pendBank_q;
   logic [AW-1:0] pendCol_q;
   sdwb_cap_if #(.DW(DW)) capBus ();
   sdwb_strobe_cap #(.DW(DW)) u_cap (
      .core_clk(core_clk),
      .srst(srst),
      .dqsIn(dqsIn),
      .dqIn(dqIn),
      .dmIn(dmIn),
      .cap(capBus.leaf)
   );
   wire newWrite = linkRise & cwSync_q;
   wire elemIn = capBus.capValid[0] | capBus.capValid[1];
   wire accept = (state_q == sdwb_pkg::SDWB_DATA) & elemIn;
   wire lastElem = accept & (elemCnt_q == 4'h1);
   // Truncation legal only for BL8 without auto precharge, two clocks in
   wire truncOk = bl8 & ~apPend_q & (sinceCmd_q == sdwb_pkg::TRUNC_GAP);
   wire truncNow = newWrite & (state_q != sdwb_pkg::SDWB_IDLE) & truncOk;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= sdwb_pkg::SDWB_IDLE;
         latCnt_q <= 4'h0;
         elemCnt_q <= 4'h0;
         sinceCmd_q <= 4'hF;
         col_q <= '0;
         apPend_q <= 1'b0;
         bank_q <= 3'h0;
         pendValid_q <= 1'b0;
         pendAp_q <= 1'b0;
         pendBank_q <= 3'h0;
         pendCol_q <= '0;
      end else begin
         if (newWrite) begin
            sinceCmd_q <= 4'h1;
         end else if (linkRise && sinceCmd_q != 4'hF) begin
            sinceCmd_q <= sinceCmd_q + 4'h1;
         end
         case (state_q)
            sdwb_pkg::SDWB_IDLE: begin
               if (newWrite) begin
                  state_q <= (writeLat == 4'h0) ? sdwb_pkg::SDWB_DATA : sdwb_pkg::SDWB_WAIT;
                  latCnt_q <= writeLat;
                  elemCnt_q <= burstLen;
                  col_q <= colSync_q;
                  apPend_q <= a10Sync_q;
                  bank_q <= bkSync_q;
               end
            end
            sdwb_pkg::SDWB_WAIT: begin
               if (truncNow) begin
                  elemCnt_q <= elemCnt_q - 4'h4;
               end
               if (linkRise) begin
                  latCnt_q <= latCnt_q - 4'h1;
                  if (latCnt_q == 4'h1) begin
                     state_q <= sdwb_pkg::SDWB_DATA;
                  end
               end
            end
            sdwb_pkg::SDWB_DATA: begin
               if (truncNow) begin
                  // Cut at the four-element boundary; the new WRITE is queued and follows gaplessly
                  elemCnt_q <= elemCnt_q - 4'h4 - 4'(accept);
                  col_q <= col_q + AW'(accept);
               end else if (accept) begin
                  elemCnt_q <= elemCnt_q - 4'h1;
                  col_q <= col_q + AW'(1);
                  if (lastElem) begin
                     if (pendValid_q) begin
                        pendValid_q <= 1'b0;
                        elemCnt_q <= burstLen;
                        col_q <= pendCol_q;
                        apPend_q <= pendAp_q;
                        bank_q <= pendBank_q;
                     end else begin
                        state_q <= sdwb_pkg::SDWB_IDLE;
                     end
                  end
               end
            end
            default: state_q <= sdwb_pkg::SDWB_IDLE;
         endcase
         // A WRITE while busy queues behind the current burst; placed last so a new
         // request in the cycle that drains the queue is kept rather than lost
         if (newWrite && state_q != sdwb_pkg::SDWB_IDLE) begin
            pendValid_q <= 1'b1;
            pendAp_q <= a10Sync_q;
            pendBank_q <= bkSync_q;
            pendCol_q <= colSync_q;
         end
      end
   end
   // ----------------------------------------------------------------
   // Memory write port and auto precharge
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         memWe <= 1'b0;
         memAddr <= '0;
         memData <= '0;
         memByteEn <= 2'h0;
         apStart <= 1'b0;
         apBank <= 3'h0;
         apCount_q <= 16'h0;
         lastData_q <= '0;
         dqOe <= 1'b0;
      end else begin
         memWe <= accept;
         memAddr <= col_q;
         memData <= capBus.capData;
         memByteEn <= ~capBus.capMask;
         if (accept) begin
            lastData_q <= capBus.capData;
         end
         // Row closes once the last element lands, no command needed
         apStart <= lastElem & apPend_q;
         if (lastElem && apPend_q) begin
            apBank <= bank_q;
            apCount_q <= apCount_q + 16'h1;
         end
         dqOe <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait, always OKAY
   // ----------------------------------------------------------------
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   wire take = hsel & hready & htrans[1];
   wire [31:0] statWord = {20'h0, elemCnt_q, latCnt_q, state_q, apPend_q, pendValid_q};
   wire [31:0] rdMux = (haddr[7:0] == sdwb_pkg::CTRL_OFS) ? ctrl_q :
                       (haddr[7:0] == sdwb_pkg::STAT_OFS) ? statWord :
                       (haddr[7:0] == sdwb_pkg::DATA_OFS) ? 32'(lastData_q) :
                       (haddr[7:0] == sdwb_pkg::PRE_OFS) ? {13'h0, apBank, apCount_q} : 32'h0;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q <= sdwb_pkg::CTRL_RST;
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wrPend_q <= take & hwrite;
         wrAddr_q <= haddr[7:0];
         if (take && !hwrite) begin
            hrdata <= rdMux;
         end
         if (wrPend_q && wrAddr_q == sdwb_pkg::CTRL_OFS) begin
            ctrl_q <= hwdata & 32'h0000_0FF7;
         end
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_ap; @(posedge core_clk) disable iff (srst)
      apStart |-> $past(lastElem) && $past(apPend_q); endproperty
   ap_after_burst_a: assert property (p_ap) else $error("precharge without burst end");
   idle_ignores_data_a: assert property (@(posedge core_clk) disable iff (srst)
      (state_q == sdwb_pkg::SDWB_IDLE) |=> !memWe) else $error("store while idle");
   mask_blocks_store_a: assert property (@(posedge core_clk) disable iff (srst)
      (accept && capBus.capMask == 2'h3) |=> memByteEn == 2'h0) else $error("masked stored");
   start_latched_a: assert property (@(posedge core_clk) disable iff (srst)
      (newWrite && state_q == sdwb_pkg::SDWB_IDLE && writeLat != 4'h0) |=> latCnt_q == $past(writeLat))
      else $error("latency wrong");
   a10_selects_ap_a: assert property (@(posedge core_clk) disable iff (srst)
      (newWrite && state_q == sdwb_pkg::SDWB_IDLE) |=> apPend_q == $past(a10Sync_q))
      else $error("auto precharge select wrong");
   count_steps_a: assert property (@(posedge core_clk) disable iff (srst)
      (accept && !lastElem && !truncNow) |=> elemCnt_q == $past(elemCnt_q) - 4'h1)
      else $error("element count stuck");
   pins_quiet_a: assert property (@(posedge core_clk) disable iff (srst) !dqOe)
      else $error("data pins driven");
   trunc_bl4_a: assert property (@(posedge core_clk) disable iff (srst)
      (newWrite && !bl8 && state_q == sdwb_pkg::SDWB_WAIT) |=> elemCnt_q == $past(elemCnt_q))
      else $error("short burst truncated");
   trunc_boundary_a: assert property (@(posedge core_clk) disable iff (srst)
      (truncNow && !accept) |=> elemCnt_q == $past(elemCnt_q) - 4'h4) else $error("cut off boundary");
endmodule : sdwb_write_burst

/* tb/sdwb_ctrl_model.sv */
// Purpose: Behavioural memory controller: link clock, WRITE commands, strobed data lanes
// Assumes: Everything steps on core_clk; one link clock spans eight core clocks
// Notes: Bursts are booked ahead in tables, so overlapping commands stream gaplessly
`timescale 1ns/1ps
module sdwb_ctrl_model #(
   parameter int DW = 16,
   parameter int AW = 10
) (
   input wire logic core_clk,
   output logic linkClk,
   output logic cmdWrite,
   output logic [2:0] cmdBank,
   output logic [AW-1:0] cmdCol,
   output logic cmdA10,
   output logic [1:0] dqsIn,
   output logic [DW-1:0] dqIn,
   output logic [1:0] dmIn
);
   int t = 0;                    // Core cycles since start
   logic [AW+3:0] cmdAt [int];   // Booked command fields per core cycle
   logic [DW+1:0] dataAt [int];  // Booked mask and data per core cycle
   logic dqsAt [int];            // Booked strobe level per core cycle

   // Quiet lines at time zero
   initial begin
      {linkClk, cmdWrite, cmdBank, cmdCol, cmdA10} = '0;
      {dqsIn, dqIn, dmIn} = '0;
   end

   // Book one WRITE at link cycle lc; n elements follow after wl link clocks
   task automatic sched(input int lc, input logic [2:0] bank, input logic [AW-1:0] col,
                        input logic a10, input int n, input int wl, input logic [DW-1:0] base);
      int first;
      for (int i = 0; i < 8; i++) begin
         cmdAt[8*lc+i] = {a10, bank, col};
      end
      first = 8*lc + 4 + 8*wl;
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 4; i++) begin
            dqsAt[first+4*k+i] = ~k[0];
            dataAt[first+4*k+i-2] = {2'(k), base + DW'(k * 32'h1111)};
         end
      end
   endtask : sched

   // Only WRITE is ever issued, so read and precharge spacing is kept by absence
   always @(posedge core_clk) begin
      t <= t + 1;
      // Free-running and never suspended, as if clock enable stays high throughout
      linkClk <= (t % 8) >= 4;
      if (cmdAt.exists(t)) begin
         cmdWrite <= 1'b1;
         {cmdA10, cmdBank, cmdCol} <= cmdAt[t];
      end else begin
         // Deselected address lines carry no stale value
         cmdWrite <= 1'b0;
         {cmdA10, cmdBank, cmdCol} <= ~{cmdA10, cmdBank, cmdCol};
      end
      dqsIn <= dqsAt.exists(t) ? {2{dqsAt[t]}} : 2'h0;
      if (dataAt.exists(t)) begin
         {dmIn, dqIn} <= dataAt[t];
      end else begin
         {dmIn, dqIn} <= ~{dmIn, dqIn};  // Outside the valid window
      end
   end
endmodule : sdwb_ctrl_model

/* tb/sdwb_write_burst_logic_test.sv */
// Purpose: Self-checking bench for the write-burst engine
// Assumes: Controller model books link traffic; registers reached over AHB-Lite
// Notes: Scenarios wait for stored elements under a bound, then compare all of them
`timescale 1ns/1ps
module sdwb_write_burst_logic_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hsel = 1'b0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, memWe, apStart, dqOe, linkClk, cmdWrite, cmdA10;
   logic [2:0] cmdBank, apBank;
   logic [9:0] cmdCol, memAddr;
   logic [1:0] dqsIn, dmIn, memByteEn;
   logic [15:0] dqIn, memData;
   logic [27:0] beats [$];     // Stored elements {addr, data, byteEn}
   logic [27:0] expBeats [$];  // Elements the rules call for
   logic [2:0] apSeen [$];     // Banks closed by auto precharge
   int miscompares = 0;
   int nCompared = 0;

   always #20 core_clk = ~core_clk;

   sdwb_ctrl_model m (.core_clk(core_clk), .linkClk(linkClk), .cmdWrite(cmdWrite), .cmdBank(cmdBank),
      .cmdCol(cmdCol), .cmdA10(cmdA10), .dqsIn(dqsIn), .dqIn(dqIn), .dmIn(dmIn));

   sdwb_write_burst dut (.core_clk(core_clk), .srst(srst), .linkClk(linkClk), .cmdWrite(cmdWrite),
      .cmdBank(cmdBank), .cmdCol(cmdCol), .cmdA10(cmdA10), .dqsIn(dqsIn), .dqIn(dqIn), .dmIn(dmIn),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memWe(memWe),
      .memAddr(memAddr), .memData(memData), .memByteEn(memByteEn), .apStart(apStart),
      .apBank(apBank), .dqOe(dqOe));

   // Collect stores and precharges; the write path must never drive the pins
   always @(posedge core_clk) begin
      if (memWe === 1'b1) beats.push_back({memAddr, memData, memByteEn});
      if (apStart === 1'b1) apSeen.push_back(apBank);
      if (!srst && dqOe !== 1'b0) fail("data pins driven");
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic fail(input string msg);
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : fail

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      nCompared++;
      if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
   endtask : cmp_word

   // Single word transfer; address phase held until hready, data taken at the second edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      if (hresp !== 1'b0) fail("error response");
   endtask : ahb

   task automatic expect_burst(input logic [9:0] col, input int n, input logic [15:0] base);
      for (int k = 0; k < n; k++) begin
         expBeats.push_back({col + 10'(k), base + 16'(k * 32'h1111), ~2'(k)});
      end
   endtask : expect_burst

   // Wait for the expected count, allow strays to show, compare unmasked bytes
   task automatic cmp_beats(input string what);
      int guard;
      logic [27:0] keep;
      guard = 0;
      while (beats.size() < expBeats.size() && guard < 600) begin
         @(posedge core_clk);
         guard++;
      end
      repeat (48) @(posedge core_clk);
      cmp_word(32'(beats.size()), 32'(expBeats.size()), {what, " count"});
      foreach (expBeats[i]) begin
         keep = {10'h3FF, {8{expBeats[i][1]}}, {8{expBeats[i][0]}}, 2'h3};
         if (i < beats.size()) cmp_word(32'(beats[i] & keep), 32'(expBeats[i] & keep), what);
      end
      beats.delete();
      expBeats.delete();
   endtask : cmp_beats

   task automatic cmp_ap(input int n, input logic [2:0] bank);
      cmp_word(32'(apSeen.size()), 32'(n), "precharge count");
      foreach (apSeen[i]) cmp_word(32'(apSeen[i]), 32'(bank), "precharge bank");
      apSeen.delete();
   endtask : cmp_ap

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic reset_values();
      ahb(1'b0, 32'(sdwb_pkg::CTRL_OFS), 32'h0);
      cmp_word(rd, sdwb_pkg::CTRL_RST, "control reset");
      ahb(1'b0, 32'(sdwb_pkg::PRE_OFS), 32'h0);
      cmp_word(rd, 32'h0, "precharge reset");
      ahb(1'b0, 32'(sdwb_pkg::STAT_OFS), 32'h0);
      cmp_word(rd, 32'h0, "status reset");
      ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h20, 32'h0);
      cmp_word(rd, 32'h0, "unmapped read");
   endtask : reset_values

   // Two surplus elements after a four-element burst must be dropped
   task automatic single_bl4();
      m.sched(m.t / 8 + 2, 3'h1, 10'h040, 1'b0, 6, 2, 16'hA050);
      expect_burst(10'h040, 4, 16'hA050);
      cmp_beats("single burst");
      cmp_ap(0, 3'h0);
      ahb(1'b0, 32'(sdwb_pkg::DATA_OFS), 32'h0);
      cmp_word(rd, 32'h0000_D383, "last element");
   endtask : single_bl4

   // Next WRITE one burst (two link clocks) later; the second closes its row
   task automatic gapless_bl4();
      int lc;
      lc = m.t / 8 + 2;
      m.sched(lc, 3'h2, 10'h080, 1'b0, 4, 2, 16'h1200);
      m.sched(lc + 2, 3'h5, 10'h0C0, 1'b1, 4, 2, 16'h3400);
      expect_burst(10'h080, 4, 16'h1200);
      expect_burst(10'h0C0, 4, 16'h3400);
      cmp_beats("gapless bursts");
      cmp_ap(1, 3'h5);
      ahb(1'b0, 32'(sdwb_pkg::PRE_OFS), 32'h0);
      cmp_word(rd, 32'h0005_0001, "precharge record");
   endtask : gapless_bl4

   // Eight-element burst cut at four by a WRITE exactly two link clocks later
   task automatic truncate_bl8();
      int lc;
      ahb(1'b1, 32'(sdwb_pkg::CTRL_OFS), 32'h0000_0B14);
      ahb(1'b0, 32'(sdwb_pkg::CTRL_OFS), 32'h0);
      cmp_word(rd, 32'h0000_0B14, "control readback");
      lc = m.t / 8 + 2;
      m.sched(lc, 3'h2, 10'h100, 1'b0, 4, 4, 16'h5600);
      m.sched(lc + 2, 3'h3, 10'h140, 1'b0, 8, 4, 16'h7800);
      expect_burst(10'h100, 4, 16'h5600);
      expect_burst(10'h140, 8, 16'h7800);
      cmp_beats("truncated burst");
      cmp_ap(0, 3'h0);
   endtask : truncate_bl8

   // Full eight-element burst at the top column with auto precharge
   task automatic ap_bl8();
      m.sched(m.t / 8 + 2, 3'h7, 10'h3F8, 1'b1, 8, 4, 16'h9A00);
      expect_burst(10'h3F8, 8, 16'h9A00);
      cmp_beats("precharged burst");
      cmp_ap(1, 3'h7);
      ahb(1'b0, 32'(sdwb_pkg::PRE_OFS), 32'h0);
      cmp_word(rd, 32'h0007_0002, "precharge record");
      ahb(1'b0, 32'(sdwb_pkg::STAT_OFS), 32'h0);
      cmp_word(rd, 32'h0000_0002, "status after burst");
   endtask : ap_bl8

   task automatic complete_run();
      if (miscompares == 0 && nCompared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      reset_values();
      single_bl4();
      gapless_bl4();
      truncate_bl8();
      ap_bl8();
      complete_run();
   end

   // Watchdog, far beyond the several hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge core_clk);
      fail("timeout");
      complete_run();
   end
endmodule : sdwb_write_burst_logic_test
